// ===== hw/dpdc_cfg.svh
// constants of the dual prescaled down-counter block
`ifndef DPDC_CFG_SVH
`define DPDC_CFG_SVH

`define DPDC_ADDR_MODE      8'hF1
`define DPDC_ADDR_CNT1      8'hF2
`define DPDC_ADDR_PRESCALER1_CONFIG      8'hF3
`define DPDC_ADDR_CNT0      8'hF4
`define DPDC_ADDR_PRESCALER0_CONFIG      8'hF5

`define DPDC_MODE_LOAD0     0
`define DPDC_MODE_EN0       1
`define DPDC_MODE_LOAD1     2
`define DPDC_MODE_EN1       3
`define DPDC_MODE_SEL_LO    6
`define DPDC_MODE_SEL_HI    7

`define DPDC_PRE_CONT       0
`define DPDC_PRE_INPUT_EN   1
`define DPDC_PRE_CLK_INT    2
`define DPDC_PRE_MOD_LO     2
`define DPDC_PRE_MOD_HI     7

`define DPDC_RESET_MODE     8'h00
`define DPDC_RESET_PRE      8'h00
`define DPDC_RESET_CNT      8'h00
`define DPDC_PRE_READ       8'hFF

`define DPDC_TCLK_DIV       4

`endif

// ===== hw/dpdc_chan.sv
// one 6-bit prescaler plus 8-bit down-counter channel
`timescale 1ns/1ps
`default_nettype none

`include "dpdc_cfg.svh"

module dpdc_chan
	import dpdc_pkg::*;
#(
	parameter int TCLK_DIV = `DPDC_TCLK_DIV
) (
	input  wire logic  clk_in,    // internal clock
	input  wire logic  rst_b_in,  // synchronous reset, active low
	dpdc_chan_if.chan  ch         // control and status of this channel
);
	localparam int PW = (TCLK_DIV > 1) ? $clog2(TCLK_DIV) : 1;

	if (TCLK_DIV < 2 || TCLK_DIV > 256) begin : g_bad_div
		$error("TCLK_DIV must lie in 2..256");
	end

	logic [PW-1:0]    phase_reg;
	logic [PW-1:0]    phase_next;
	dpdc_modulus_t    pre_reg;
	dpdc_byte_t       cnt_reg;
	logic             eoc_reg;
	dpdc_chan_state_t state_reg;

	wire int_tick = (phase_reg == PW'(TCLK_DIV - 1));
	wire tick     = ch.use_ext ? ch.ext_edge : int_tick;
	wire pre_end  = (pre_reg == 6'h01);
	wire cnt_end  = (cnt_reg == 8'h01);
	wire active   = ch.enable && (state_reg == DPDC_CH_COUNTING);

	// phase restarts while disabled so the first tick lands a full period later;
	// a load keeps the phase, so load with enable still decrements four clocks on
	assign phase_next = (!ch.enable || int_tick) ? '0 : phase_reg + PW'(1);

	always_ff @(posedge clk_in) begin
		if (!rst_b_in)
			phase_reg <= '0;
		else
			phase_reg <= phase_next;
	end

	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			pre_reg   <= '0;
			cnt_reg   <= `DPDC_RESET_CNT;
			eoc_reg   <= 1'b0;
			state_reg <= DPDC_CH_COUNTING;
		end else begin
			eoc_reg <= 1'b0;
			if (ch.load) begin
				pre_reg   <= ch.modulus;
				cnt_reg   <= ch.init_val;
				state_reg <= DPDC_CH_COUNTING;
			end else if (active && tick) begin
				if (pre_end) begin
					pre_reg <= ch.modulus;
					if (cnt_end) begin
						eoc_reg <= 1'b1;
						case (ch.continuous)
							1'b1:    cnt_reg <= ch.init_val;
							default: begin
								cnt_reg   <= 8'h00;
								state_reg <= DPDC_CH_AT_REST;
							end
						endcase
					end else begin
						// zero wraps to FF here, which is how 00 gives 256 counts
						cnt_reg <= cnt_reg - 8'h01;
					end
				end else begin
					pre_reg <= pre_reg - 6'h01;
				end
			end
		end
	end

	assign ch.count = cnt_reg;
	assign ch.eoc   = eoc_reg;
endmodule : dpdc_chan

`default_nettype wire

// ===== hw/dpdc_chan_if.sv
// signals between the register logic and one counter channel
`timescale 1ns/1ps
`default_nettype none

interface dpdc_chan_if;
	import dpdc_pkg::*;

	logic          load;
	logic          enable;
	logic          continuous;
	dpdc_modulus_t modulus;
	dpdc_byte_t    init_val;
	logic          use_ext;
	logic          ext_edge;
	dpdc_byte_t    count;
	logic          eoc;

	modport ctrl (
		output load, enable, continuous, modulus, init_val, use_ext, ext_edge,
		input  count, eoc
	);
	modport chan (
		input  load, enable, continuous, modulus, init_val, use_ext, ext_edge,
		output count, eoc
	);
	modport obs (
		input  load, eoc
	);
endinterface : dpdc_chan_if

`default_nettype wire

// ===== hw/dpdc_pkg.sv
// types shared by the dual prescaled down-counter modules
`default_nettype none

package dpdc_pkg;

	typedef logic [7:0] dpdc_byte_t;
	typedef logic [5:0] dpdc_modulus_t;

	typedef enum {
		DPDC_TOUT_OFF,
		DPDC_TOUT_CH0,
		DPDC_TOUT_CH1,
		DPDC_TOUT_CLK
	} dpdc_tout_sel_t;

	typedef enum {
		DPDC_CH_COUNTING,
		DPDC_CH_AT_REST
	} dpdc_chan_state_t;

endpackage : dpdc_pkg

`default_nettype wire

// ===== hw/dpdc_top.sv
// dual prescaled down-counter: register file, input sync and channels
`timescale 1ns/1ps
`default_nettype none

`include "dpdc_cfg.svh"

module dpdc_top
	import dpdc_pkg::*;
(
	input  wire logic       CLK_IN,                  // internal clock, 125 MHz
	input  wire logic       RST_B_IN,                // synchronous reset, active low
	input  wire logic [7:0] REG_ADDR_IN,             // register file address
	input  wire logic       REG_WR_EN_IN,            // write strobe
	input  wire logic       REG_RD_EN_IN,            // read strobe
	input  wire logic [7:0] REG_WDATA_IN,            // write data
	output logic      [7:0] REG_RDATA_OUT,           // read data, one cycle after strobe
	output logic            REG_RVALID_OUT,          // read data valid pulse
	input  wire logic       TIMER_INPUT_PIN_IN,      // external clock for second timer
	input  wire logic       PORT_DATA_BIT_IN,        // port data bit of the shared pin
	input  wire logic       PORT_PIN_IS_OUTPUT_IN,   // port mode makes the pin an output
	output logic            FIRST_TIMER_IRQ_OUT,     // first timer end-of-count pulse
	output logic            SECOND_TIMER_IRQ_OUT,    // second timer end-of-count pulse
	output logic            TOGGLE_OUTPUT_PIN_OUT,   // shared pin drive level
	output logic            TOGGLE_OUTPUT_PIN_OE_OUT // shared pin output enable
);
	dpdc_byte_t mode_reg;
	dpdc_byte_t mode_next;
	dpdc_byte_t prescaler0_config_reg;
	dpdc_byte_t prescaler1_config_reg;
	dpdc_byte_t init0_reg;
	dpdc_byte_t init1_reg;
	dpdc_byte_t rdata_reg;
	dpdc_byte_t rdata_next;
	logic       rvalid_reg;

	logic       tin_s1_reg;
	logic       tin_s2_reg;
	logic       tin_s3_reg;
	logic       tin_level_reg;

	logic       pin_level;

	dpdc_chan_if ch0_if ();
	dpdc_chan_if ch1_if ();

	// address decode
	wire sel_mode = (REG_ADDR_IN == `DPDC_ADDR_MODE);
	wire sel_cnt1 = (REG_ADDR_IN == `DPDC_ADDR_CNT1);
	wire sel_prescaler1_config = (REG_ADDR_IN == `DPDC_ADDR_PRESCALER1_CONFIG);
	wire sel_cnt0 = (REG_ADDR_IN == `DPDC_ADDR_CNT0);
	wire sel_prescaler0_config = (REG_ADDR_IN == `DPDC_ADDR_PRESCALER0_CONFIG);

	wire wr_mode = REG_WR_EN_IN && sel_mode;
	wire wr_cnt1 = REG_WR_EN_IN && sel_cnt1;
	wire wr_prescaler1_config = REG_WR_EN_IN && sel_prescaler1_config;
	wire wr_cnt0 = REG_WR_EN_IN && sel_cnt0;
	wire wr_prescaler0_config = REG_WR_EN_IN && sel_prescaler0_config;

	function automatic dpdc_modulus_t modulus_of(input dpdc_byte_t pre);
		modulus_of = pre[`DPDC_PRE_MOD_HI:`DPDC_PRE_MOD_LO];
	endfunction : modulus_of

	// load bits live one clock; a write of zero to them has no further effect
	always_comb begin
		mode_next = mode_reg;
		mode_next[`DPDC_MODE_LOAD0] = 1'b0;
		mode_next[`DPDC_MODE_LOAD1] = 1'b0;
		if (wr_mode)
			mode_next = REG_WDATA_IN;
	end

	always_ff @(posedge CLK_IN) begin
		if (!RST_B_IN)
			mode_reg <= `DPDC_RESET_MODE;
		else
			mode_reg <= mode_next;
	end

	// count and modulus fields feed the counters only at a load or reload; the continuous and clock-source bits act at once
	always_ff @(posedge CLK_IN) begin
		if (!RST_B_IN) begin
			prescaler0_config_reg  <= `DPDC_RESET_PRE;
			prescaler1_config_reg  <= `DPDC_RESET_PRE;
			init0_reg <= `DPDC_RESET_CNT;
			init1_reg <= `DPDC_RESET_CNT;
		end else begin
			if (wr_prescaler0_config)
				prescaler0_config_reg <= REG_WDATA_IN;
			if (wr_prescaler1_config)
				prescaler1_config_reg <= REG_WDATA_IN;
			if (wr_cnt0)
				init0_reg <= REG_WDATA_IN;
			if (wr_cnt1)
				init1_reg <= REG_WDATA_IN;
		end
	end

	// read mux; unmapped addresses read as zero
	always_comb begin
		rdata_next = 8'h00;
		if (sel_mode)
			rdata_next = mode_reg;
		else if (sel_prescaler0_config || sel_prescaler1_config)
			rdata_next = `DPDC_PRE_READ;
		else if (sel_cnt0)
			rdata_next = ch0_if.count;
		else if (sel_cnt1)
			rdata_next = ch1_if.count;
	end

	always_ff @(posedge CLK_IN) begin
		if (!RST_B_IN) begin
			rdata_reg  <= 8'h00;
			rvalid_reg <= 1'b0;
		end else begin
			rvalid_reg <= REG_RD_EN_IN;
			if (REG_RD_EN_IN)
				rdata_reg <= rdata_next;
		end
	end

	// external input: three flops, level accepted once the last two agree
	always_ff @(posedge CLK_IN) begin
		if (!RST_B_IN) begin
			tin_s1_reg    <= 1'b1;
			tin_s2_reg    <= 1'b1;
			tin_s3_reg    <= 1'b1;
			tin_level_reg <= 1'b1;
		end else begin
			tin_s1_reg <= TIMER_INPUT_PIN_IN;
			tin_s2_reg <= tin_s1_reg;
			tin_s3_reg <= tin_s2_reg;
			if (tin_s2_reg == tin_s3_reg)
				tin_level_reg <= tin_s3_reg;
		end
	end

	// a high-to-low change of the filtered level is one external clock event
	wire tin_fall = tin_level_reg && !tin_s2_reg && !tin_s3_reg;

	assign ch0_if.load       = mode_reg[`DPDC_MODE_LOAD0];
	assign ch0_if.enable     = mode_reg[`DPDC_MODE_EN0];
	assign ch0_if.continuous = prescaler0_config_reg[`DPDC_PRE_CONT];
	assign ch0_if.modulus    = modulus_of(prescaler0_config_reg);
	assign ch0_if.init_val   = init0_reg;
	assign ch0_if.use_ext    = 1'b0;
	assign ch0_if.ext_edge   = 1'b0;

	assign ch1_if.load       = mode_reg[`DPDC_MODE_LOAD1];
	assign ch1_if.enable     = mode_reg[`DPDC_MODE_EN1];
	assign ch1_if.continuous = prescaler1_config_reg[`DPDC_PRE_CONT];
	assign ch1_if.modulus    = modulus_of(prescaler1_config_reg);
	assign ch1_if.init_val   = init1_reg;
	assign ch1_if.use_ext    = !prescaler1_config_reg[`DPDC_PRE_CLK_INT];
	assign ch1_if.ext_edge   = tin_fall;

	dpdc_chan #(
		.TCLK_DIV (`DPDC_TCLK_DIV)
	) u_ch0 (
		.clk_in   (CLK_IN),
		.rst_b_in (RST_B_IN),
		.ch       (ch0_if.chan)
	);

	dpdc_chan #(
		.TCLK_DIV (`DPDC_TCLK_DIV)
	) u_ch1 (
		.clk_in   (CLK_IN),
		.rst_b_in (RST_B_IN),
		.ch       (ch1_if.chan)
	);

	dpdc_tout u_tout (
		.clk_in       (CLK_IN),
		.rst_b_in     (RST_B_IN),
		.sel_in       (mode_reg[`DPDC_MODE_SEL_HI:`DPDC_MODE_SEL_LO]),
		.port_data_in (PORT_DATA_BIT_IN),
		.ch0          (ch0_if.obs),
		.ch1          (ch1_if.obs),
		.pin_out      (pin_level)
	);

	assign REG_RDATA_OUT  = rdata_reg;
	assign REG_RVALID_OUT = rvalid_reg;

	assign FIRST_TIMER_IRQ_OUT  = ch0_if.eoc;
	assign SECOND_TIMER_IRQ_OUT = ch1_if.eoc;

	// pin only drives when the port side has made it an output
	assign TOGGLE_OUTPUT_PIN_OUT    = pin_level;
	assign TOGGLE_OUTPUT_PIN_OE_OUT = PORT_PIN_IS_OUTPUT_IN;
endmodule : dpdc_top

`default_nettype wire

// ===== hw/dpdc_tout.sv
// toggle output flip-flop and pin source selection
`timescale 1ns/1ps
`default_nettype none

module dpdc_tout
	import dpdc_pkg::*;
(
	input  wire logic     clk_in,       // internal clock
	input  wire logic     rst_b_in,     // synchronous reset, active low
	input  wire logic [1:0] sel_in,     // output source select
	input  wire logic     port_data_in, // port data bit for this pin
	dpdc_chan_if.obs      ch0,          // first channel
	dpdc_chan_if.obs      ch1,          // second channel
	output logic          pin_out       // registered pin level
);
	logic toggle_reg;
	logic clk_half_reg;

	dpdc_tout_sel_t sel;
	assign sel = dpdc_tout_sel_t'(sel_in);

	wire sel_eoc = (sel == DPDC_TOUT_CH0) ? ch0.eoc :
	               (sel == DPDC_TOUT_CH1) ? ch1.eoc : 1'b0;

	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			toggle_reg   <= 1'b1;
			clk_half_reg <= 1'b0;
		end else begin
			clk_half_reg <= ~clk_half_reg;
			if (ch0.load || ch1.load)
				toggle_reg <= 1'b1;
			else if (sel_eoc)
				toggle_reg <= ~toggle_reg;
		end
	end

	// clock output can only be shown at half rate from inside the clock domain
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			pin_out <= 1'b0;
		end else begin
			case (sel)
				DPDC_TOUT_OFF: pin_out <= port_data_in;
				DPDC_TOUT_CLK: pin_out <= clk_half_reg;
				default:       pin_out <= toggle_reg;
			endcase
		end
	end
endmodule : dpdc_tout

`default_nettype wire

// ===== sim/dpdc_pin_model.sv
// far side of the shared pin and the external count input
`timescale 1ns/1ps
`default_nettype none
module dpdc_pin_model (
	input  wire logic clk_in,   // clock
	input  wire logic drive_in, // block drives pin
	input  wire logic level_in, // driven level
	input  wire logic run_in,   // external clock on
	output logic      pin_out,  // pin level
	output logic      tin_out   // external clock
);
	logic       last_reg = 1'b0;
	logic [3:0] div_reg  = 4'h0;
	// a released pin shows the inverse level so a stale value cannot pass
	assign pin_out = drive_in ? level_in : ~last_reg;
	assign tin_out = !run_in || div_reg < 4'h5;
	always @(posedge clk_in) begin
		if (drive_in) last_reg <= level_in;
	end
	always @(negedge clk_in) begin
		if (run_in) div_reg <= (div_reg == 4'h9) ? 4'h0 : div_reg + 4'h1;
	end
endmodule : dpdc_pin_model
`default_nettype wire

// ===== sim/dpdc_top_monitor.sv
// port assertions for the dual down-counter
`timescale 1ns/1ps
`default_nettype none
module dpdc_top_monitor (
	input wire logic       CLK_IN,                  // clock
	input wire logic       RST_B_IN,                // reset
	input wire logic [7:0] REG_ADDR_IN,             // address
	input wire logic       REG_WR_EN_IN,            // write
	input wire logic       REG_RD_EN_IN,            // read
	input wire logic [7:0] REG_WDATA_IN,            // wdata
	input wire logic [7:0] REG_RDATA_OUT,           // rdata
	input wire logic       REG_RVALID_OUT,          // rvalid
	input wire logic       PORT_PIN_IS_OUTPUT_IN,   // pin mode
	input wire logic       FIRST_TIMER_IRQ_OUT,     // irq 0
	input wire logic       SECOND_TIMER_IRQ_OUT,    // irq 1
	input wire logic       TOGGLE_OUTPUT_PIN_OUT,   // pin
	input wire logic       TOGGLE_OUTPUT_PIN_OE_OUT // pin oe
);
	logic [1:0] sel_reg;
	logic [7:0] prescaler0_config_reg;
	logic [7:0] cnt0_reg;
	wire        wr_mode = REG_WR_EN_IN && REG_ADDR_IN == 8'hF1;
	always_ff @(posedge CLK_IN) begin
		if (!RST_B_IN) begin
			sel_reg  <= 2'h0;
			prescaler0_config_reg <= 8'h00;
			cnt0_reg <= 8'h00;
		end else begin
			if (wr_mode) sel_reg <= REG_WDATA_IN[7:6];
			if (REG_WR_EN_IN && REG_ADDR_IN == 8'hF5) prescaler0_config_reg <= REG_WDATA_IN;
			if (REG_WR_EN_IN && REG_ADDR_IN == 8'hF4) cnt0_reg <= REG_WDATA_IN;
		end
	end
	default clocking cb @(posedge CLK_IN);
	endclocking
	default disable iff (!RST_B_IN);
	sequence s_load0;
		wr_mode && REG_WDATA_IN[0];
	endsequence
	sequence s_first_end;
		!FIRST_TIMER_IRQ_OUT [*5] ##1 FIRST_TIMER_IRQ_OUT;
	endsequence
	a_read_answer: assert property (REG_RD_EN_IN |=> REG_RVALID_OUT)
		else $error("read not answered");
	a_pre_ones: assert property (
		REG_RD_EN_IN && (REG_ADDR_IN == 8'hF3 || REG_ADDR_IN == 8'hF5)
		|=> REG_RDATA_OUT == 8'hFF) else $error("prescaler read not all ones");
	a_irq0_pulse: assert property (FIRST_TIMER_IRQ_OUT |=> !FIRST_TIMER_IRQ_OUT)
		else $error("first request too long");
	a_irq1_pulse: assert property (SECOND_TIMER_IRQ_OUT |=> !SECOND_TIMER_IRQ_OUT)
		else $error("second request too long");
	a_oe_follows: assert property (TOGGLE_OUTPUT_PIN_OE_OUT == PORT_PIN_IS_OUTPUT_IN)
		else $error("pin enable wrong");
	a_load_pin_high: assert property (
		s_load0 ##0 REG_WDATA_IN[7:6] == 2'h1 |-> ##[1:3] TOGGLE_OUTPUT_PIN_OUT)
		else $error("load left pin low");
	a_first_tick: assert property (
		s_load0 ##0 (REG_WDATA_IN[1] && prescaler0_config_reg[7:2] == 6'h01 && cnt0_reg == 8'h01)
		|-> s_first_end) else $error("first end of count mistimed");
	a_toggle_cause: assert property (
		sel_reg == 2'h1 && $past(sel_reg, 3) == 2'h1 && $fell(TOGGLE_OUTPUT_PIN_OUT)
		|-> $past(FIRST_TIMER_IRQ_OUT) || $past(FIRST_TIMER_IRQ_OUT, 2))
		else $error("pin fell without end of count");
endmodule : dpdc_top_monitor
bind dpdc_top dpdc_top_monitor u_mon (.CLK_IN, .RST_B_IN, .REG_ADDR_IN, .REG_WR_EN_IN,
	.REG_RD_EN_IN, .REG_WDATA_IN, .REG_RDATA_OUT, .REG_RVALID_OUT, .PORT_PIN_IS_OUTPUT_IN,
	.FIRST_TIMER_IRQ_OUT, .SECOND_TIMER_IRQ_OUT, .TOGGLE_OUTPUT_PIN_OUT,
	.TOGGLE_OUTPUT_PIN_OE_OUT);
`default_nettype wire

// ===== sim/tb_top.sv
// self-checking bench for the dual down-counter
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import dpdc_pkg::*;
	logic       clk   = 1'b0;
	logic       rst_b = 1'b0;
	logic       wr    = 1'b0;
	logic       rd    = 1'b0;
	logic       pdat  = 1'b0;
	logic       pout  = 1'b1; // pin set as output first
	logic       run   = 1'b0;
	logic       p;
	dpdc_byte_t addr  = 8'h00;
	dpdc_byte_t wdat  = 8'h00;
	dpdc_byte_t rdat, v, w;
	logic       rvld, irq0, irq1, tpin, toe, pin, timer_input_pin;
	int         n;
	int         bad_count    = 0;
	int         total_checks = 0;
	always #4 clk = ~clk;
	dpdc_top DUT (.CLK_IN(clk), .RST_B_IN(rst_b), .REG_ADDR_IN(addr), .REG_WR_EN_IN(wr),
		.REG_RD_EN_IN(rd), .REG_WDATA_IN(wdat), .REG_RDATA_OUT(rdat), .REG_RVALID_OUT(rvld),
		.TIMER_INPUT_PIN_IN(timer_input_pin), .PORT_DATA_BIT_IN(pdat), .PORT_PIN_IS_OUTPUT_IN(pout),
		.FIRST_TIMER_IRQ_OUT(irq0), .SECOND_TIMER_IRQ_OUT(irq1),
		.TOGGLE_OUTPUT_PIN_OUT(tpin), .TOGGLE_OUTPUT_PIN_OE_OUT(toe));
	dpdc_pin_model PM (.clk_in(clk), .drive_in(toe), .level_in(tpin), .run_in(run),
		.pin_out(pin), .tin_out(timer_input_pin));
	task automatic finish_test;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : finish_test
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr_reg(input dpdc_byte_t a, input dpdc_byte_t d);
		@(negedge clk);
		wr   = 1'b1;
		addr = a;
		wdat = d;
		@(negedge clk);
		wr = 1'b0;
	endtask : wr_reg
	task automatic rd_reg(input dpdc_byte_t a, output dpdc_byte_t d);
		@(negedge clk);
		rd   = 1'b1;
		addr = a;
		@(negedge clk);
		rd = 1'b0;
		d  = rdat;
	endtask : rd_reg
	// counts cycles up to the next request pulse of the chosen timer
	task automatic wait_irq(input logic k, output int c);
		c = 0;
		do begin
			@(negedge clk);
			c++;
		end while ((k ? irq1 : irq0) !== 1'b1 && c < 2000);
		if (c >= 2000) begin
			bad_count++;
			finish_test();
		end
	endtask : wait_irq
	initial begin
		repeat (16) @(negedge clk);
		rst_b = 1'b1;
		rd_reg(8'hF5, v);
		chk(v, 8'hFF);
		rd_reg(8'hF3, v);
		chk(v, 8'hFF);
		wr_reg(8'hF4, 8'h01);
		rd_reg(8'hF4, v);
		chk(v, 8'h00);
		$display("registers done");
		wr_reg(8'hF5, 8'h04);
		wr_reg(8'hF1, 8'h43);
		wait_irq(1'b0, n);
		chk(n, 4);
		chk(pin, 1'b1);
		rd_reg(8'hF1, v);
		chk(v, 8'h42);
		chk(pin, 1'b0);
		pdat = 1'b1;
		repeat (3) @(negedge clk);
		chk(pin, 1'b0);
		rd_reg(8'hF4, v);
		chk(v, 8'h00);
		n = 0;
		repeat (40) begin
			@(negedge clk);
			if (irq0 !== 1'b0) n++;
		end
		chk(n, 0);
		$display("single pass done");
		wr_reg(8'hF5, 8'h05);
		wr_reg(8'hF4, 8'h00);
		wr_reg(8'hF1, 8'h43);
		repeat (2) @(negedge clk);
		chk(pin, 1'b1);
		wait_irq(1'b0, n);
		wr_reg(8'hF4, 8'h03);
		wait_irq(1'b0, n);
		chk(n, 1022);
		wait_irq(1'b0, n);
		chk(n, 12);
		repeat (5) @(negedge clk);
		wr_reg(8'hF1, 8'h40);
		rd_reg(8'hF4, v);
		chk(v, 8'h02);
		repeat (20) @(negedge clk);
		rd_reg(8'hF4, w);
		chk(w, v);
		wr_reg(8'hF1, 8'h42);
		wait_irq(1'b0, n);
		chk(n, 8);
		$display("continuous done");
		wr_reg(8'hF1, 8'h00);
		chk(pin, 1'b1);
		pdat = 1'b0;
		repeat (3) @(negedge clk);
		chk(pin, 1'b0);
		wr_reg(8'hF3, 8'h0D);
		wr_reg(8'hF2, 8'h03);
		wr_reg(8'hF1, 8'h8C);
		wait_irq(1'b1, n);
		wait_irq(1'b1, n);
		chk(n, 36);
		wr_reg(8'hF1, 8'hC0);
		repeat (3) @(negedge clk);
		n = 0;
		p = pin;
		repeat (8) begin
			@(negedge clk);
			if (pin !== p) n++;
			p = pin;
		end
		chk(n, 8);
		$display("second timer done");
		wr_reg(8'hF3, 8'h00);
		wr_reg(8'hF2, 8'h01);
		wr_reg(8'hF1, 8'h0C);
		run = 1'b1;
		wait_irq(1'b1, n);
		chk(n > 600 && n < 700, 1'b1);
		$display("external clock done");
		finish_test();
	end
endmodule : tb_top
`default_nettype wire
